// [ips_pkg.sv]
// package for the interrupt priority level select block
//
// Behaviour
// - each priority bit: 0 means low level, 1 means high level; all start at 0
// - first register bit 7 sets external request pin 0 level
// - first register bit 6 sets external request pin 1 level
// - first register bit 3 sets shared watchdog and refresh level
// - first register bit 2 sets timer channel 0 level
// - first register bit 1 sets timer channel 1 level
// - first register bit 0 sets timer channel 2 level
// - both registers are 8 bits, every bit readable and writable
// - second register clears on reset and on hardware standby entry
// - second register bit 7 sets timer channel 3 level
// - second register bit 6 sets timer channel 4 level
// - second register bit 5 sets shared DMA channels 0 and 1 level
// - second register bit 4 stores and reads back, no priority effect
// - first register clears on reset and on hardware standby entry
// - second register bit 3 sets serial channel 0 level
// - second register bit 2 sets serial channel 1 level
// - second register bit 1 sets converter level; bit 0 has no effect
package ips_pkg;
  localparam int          REG_WIDTH   = 8;
  localparam int          ADDR_WIDTH  = 4;
  localparam logic [3:0]  ADDR_FIRST  = 4'h0;
  localparam logic [3:0]  ADDR_SECOND = 4'h1;
  localparam logic [7:0]  RESET_VALUE = 8'h00;
  localparam logic [7:0]  UNMAPPED_RD = 8'h00;
  // first register bit positions
  localparam int BIT_PIN0      = 7;
  localparam int BIT_PIN1      = 6;
  localparam int BIT_PIN23     = 5;
  localparam int BIT_PIN45     = 4;
  localparam int BIT_WDOG      = 3;
  localparam int BIT_TIMER0    = 2;
  localparam int BIT_TIMER1    = 1;
  localparam int BIT_TIMER2    = 0;
  // second register bit positions
  localparam int BIT_TIMER3    = 7;
  localparam int BIT_TIMER4    = 6;
  localparam int BIT_DMA       = 5;
  localparam int BIT_SERIAL0   = 3;
  localparam int BIT_SERIAL1   = 2;
  localparam int BIT_ADC       = 1;
endpackage

// [ips_reg8.sv]
// one 8-bit software register with standby clear
`timescale 1ns/1ps
module ips_reg8 #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic             clear,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] wdata,
  output logic      [WIDTH-1:0] value
);
  logic [WIDTH-1:0] next_value;

  // the bit map only knows 8-bit registers
  if (WIDTH != ips_pkg::REG_WIDTH) begin : g_bad_width
    $error("ips_reg8: width must be 8");
  end

  // standby clear beats a write in the same cycle
  always_comb begin
    next_value = value;
    if (clear) begin
      next_value = ips_pkg::RESET_VALUE;
    end else if (load) begin
      next_value = wdata;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      value <= ips_pkg::RESET_VALUE;
    end else begin
      value <= next_value;
    end
  end
endmodule

// [ips_priority_select.sv]
// top: two priority select registers and per-source priority outputs
//
// The strobed register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module ips_priority_select (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       hwStandby,
  input  wire logic [3:0] regAddr,
  input  wire logic [7:0] regWdata,
  input  wire logic       regWrite,
  input  wire logic       regRead,
  output logic      [7:0] regRdata,
  output logic            pin0PriorityBit,
  output logic            pin1PriorityBit,
  output logic            pin23PriorityBit,
  output logic            pin45PriorityBit,
  output logic            watchdogRefreshPriorityBit,
  output logic            timerCh0PriorityBit,
  output logic            timerCh1PriorityBit,
  output logic            timerCh2PriorityBit,
  output logic            timerCh3PriorityBit,
  output logic            timerCh4PriorityBit,
  output logic            dmaPriorityBit,
  output logic            serial0PriorityBit,
  output logic            serial1PriorityBit,
  output logic            adcPriorityBit
);
  logic [7:0] priorityFirst;
  logic [7:0] prioritySecond;
  logic       standbyEntry;
  logic [7:0] next_regRdata;

  // clear every cycle while standby is high, which covers its entry
  // and keeps software from loading levels while the device sleeps
  always_comb begin
    standbyEntry = hwStandby;
  end

  ips_reg8 #(.WIDTH(ips_pkg::REG_WIDTH)) uFirst (
    .clk   (clk),
    .rstn  (rstn),
    .clear (standbyEntry),
    .load  (regWrite && regAddr == ips_pkg::ADDR_FIRST),
    .wdata (regWdata),
    .value (priorityFirst)
  );

  ips_reg8 #(.WIDTH(ips_pkg::REG_WIDTH)) uSecond (
    .clk   (clk),
    .rstn  (rstn),
    .clear (standbyEntry),
    .load  (regWrite && regAddr == ips_pkg::ADDR_SECOND),
    .wdata (regWdata),
    .value (prioritySecond)
  );

  // read data one cycle after the strobe; unmapped reads give zero
  always_comb begin
    next_regRdata = ips_pkg::UNMAPPED_RD;
    if (regRead) begin
      case (regAddr)
        ips_pkg::ADDR_FIRST:  next_regRdata = priorityFirst;
        ips_pkg::ADDR_SECOND: next_regRdata = prioritySecond;
        default:              next_regRdata = ips_pkg::UNMAPPED_RD;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      regRdata <= ips_pkg::UNMAPPED_RD;
    end else begin
      regRdata <= next_regRdata;
    end
  end

  // outputs are register bits themselves, so a write shows next cycle
  always_comb begin
    pin0PriorityBit            = priorityFirst[ips_pkg::BIT_PIN0];
    pin1PriorityBit            = priorityFirst[ips_pkg::BIT_PIN1];
    pin23PriorityBit           = priorityFirst[ips_pkg::BIT_PIN23];
    pin45PriorityBit           = priorityFirst[ips_pkg::BIT_PIN45];
    watchdogRefreshPriorityBit = priorityFirst[ips_pkg::BIT_WDOG];
    timerCh0PriorityBit        = priorityFirst[ips_pkg::BIT_TIMER0];
    timerCh1PriorityBit        = priorityFirst[ips_pkg::BIT_TIMER1];
    timerCh2PriorityBit        = priorityFirst[ips_pkg::BIT_TIMER2];
    timerCh3PriorityBit        = prioritySecond[ips_pkg::BIT_TIMER3];
    timerCh4PriorityBit        = prioritySecond[ips_pkg::BIT_TIMER4];
    dmaPriorityBit             = prioritySecond[ips_pkg::BIT_DMA];
    serial0PriorityBit         = prioritySecond[ips_pkg::BIT_SERIAL0];
    serial1PriorityBit         = prioritySecond[ips_pkg::BIT_SERIAL1];
    adcPriorityBit             = prioritySecond[ips_pkg::BIT_ADC];
  end
endmodule

// [ips_props.sv]
// checker for the priority select registers
`timescale 1ns/1ps
module ips_props (
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic       hwStandby,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic       regWrite,
  input wire logic       regRead,
  input wire logic [7:0] regRdata,
  input wire logic       pin0PriorityBit,
  input wire logic       timerCh2PriorityBit,
  input wire logic       timerCh3PriorityBit,
  input wire logic       adcPriorityBit
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // a write that standby does not override
  sequence wr_s(a);
    regWrite && regAddr == a && !hwStandby;
  endsequence
  wr_pin0_a: assert property (wr_s(4'h0) |=> pin0PriorityBit == $past(regWdata[7]))
    else $error("pin0 level wrong");
  wr_timer2_a: assert property (wr_s(4'h0) |=> timerCh2PriorityBit == $past(regWdata[0]))
    else $error("timer2 level wrong");
  wr_timer3_a: assert property (wr_s(4'h1) |=> timerCh3PriorityBit == $past(regWdata[7]))
    else $error("timer3 level wrong");
  wr_adc_a: assert property (wr_s(4'h1) |=> adcPriorityBit == $past(regWdata[1]))
    else $error("adc level wrong");
  standby_clear_a: assert property (hwStandby |=> !pin0PriorityBit && !timerCh3PriorityBit && !adcPriorityBit)
    else $error("standby did not clear");
  // levels only move on a write or a clear
  hold_level_a: assert property (!regWrite && !hwStandby |=> $stable(pin0PriorityBit) && $stable(adcPriorityBit))
    else $error("level moved without write");
  rd_idle_a: assert property (!regRead |=> regRdata == 8'h00)
    else $error("read data outside read slot");
  rd_unmapped_a: assert property (regRead && regAddr > 4'h1 |=> regRdata == 8'h00)
    else $error("unmapped read not zero");
endmodule

// [ips_arb_model.sv]
// arbitration side model: counts sources at high level
`timescale 1ns/1ps
module ips_arb_model (
  input  wire logic [13:0] levels,
  output logic      [3:0]  highCount
);
  // a 1 means level 1, so ones count the high sources
  always_comb highCount = 4'($countones(levels));
endmodule

// [tb_top.sv]
// testbench for the priority select block
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; $display("BAD %s exp %h got %h", n, e, g); end end
module tb_top;
  logic       clk = 0, rstn = 0, hwStandby = 0, regWrite = 0, regRead = 0;
  logic [3:0] regAddr = 4'h0, highCount;
  logic [7:0] regWdata = 8'h00, regRdata, firstOut, d;
  logic [5:0] secondOut;
  int         n_mismatch = 0, comparisons = 0;
  ips_priority_select dut_u (.clk(clk), .rstn(rstn), .hwStandby(hwStandby), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .pin0PriorityBit(firstOut[7]), .pin1PriorityBit(firstOut[6]), .pin23PriorityBit(firstOut[5]),
    .pin45PriorityBit(firstOut[4]), .watchdogRefreshPriorityBit(firstOut[3]), .timerCh0PriorityBit(firstOut[2]),
    .timerCh1PriorityBit(firstOut[1]), .timerCh2PriorityBit(firstOut[0]), .timerCh3PriorityBit(secondOut[5]),
    .timerCh4PriorityBit(secondOut[4]), .dmaPriorityBit(secondOut[3]), .serial0PriorityBit(secondOut[2]),
    .serial1PriorityBit(secondOut[1]), .adcPriorityBit(secondOut[0]));
  ips_arb_model arb_u (.levels({firstOut, secondOut}), .highCount(highCount));
  // clock, 100 ns period
  initial forever #50 clk = ~clk;
  task automatic give_verdict;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // one-cycle strobes, settled values sampled 1 ns after the edge
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk) begin regWrite <= 1'b1; regAddr <= a; regWdata <= v; end
    @(posedge clk) regWrite <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk) begin regRead <= 1'b1; regAddr <= a; end
    @(posedge clk) regRead <= 1'b0;
    #1 `CHK("regRdata", e, regRdata)
  endtask
  // hang guard, about ten times the roughly 100 cycles needed
  initial begin
    #100000;
    n_mismatch++;
    give_verdict();
  end
  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    rd(4'h0, 8'h00);
    rd(4'h1, 8'h00);
    `CHK("levels", 14'h0000, {firstOut, secondOut})
    // walk one bit through both registers
    for (int i = 0; i < 8; i++) begin
      d = 8'h01 << i;
      wr(4'h0, d);
      wr(4'h1, d);
      `CHK("first", d, firstOut)
      `CHK("second", {d[7:5], d[3:1]}, secondOut)
      `CHK("highCount", ((d & 8'hEE) != 8'h00) ? 4'h2 : 4'h1, highCount)
      rd(4'h0, d);
      rd(4'h1, d);
    end
    wr(4'h2, 8'hFF);
    rd(4'h2, 8'h00);
    rd(4'h0, 8'h80);
    // standby entry beats a write in the same cycle
    @(posedge clk) begin hwStandby <= 1'b1; regWrite <= 1'b1; regAddr <= 4'h1; regWdata <= 8'hFF; end
    @(posedge clk) begin hwStandby <= 1'b0; regWrite <= 1'b0; end
    rd(4'h0, 8'h00);
    rd(4'h1, 8'h00);
    // mid-run reset must clear levels that were set
    wr(4'h0, 8'hA5);
    wr(4'h1, 8'h5A);
    @(posedge clk) rstn <= 1'b0;
    @(posedge clk) rstn <= 1'b1;
    #1 `CHK("levels", 14'h0000, {firstOut, secondOut})
    rd(4'h0, 8'h00);
    rd(4'h1, 8'h00);
    give_verdict();
  end
endmodule
bind ips_priority_select ips_props chk_u (.*);
